/* File: msc_defs.vh */
/*
 * Register map, field positions, reset values and timing counts for the
 * motion sensor control register bank.
 * Assumes a 125 MHz system clock and a byte-wide serial register port.
 */
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
`define MSC_ADDR_PULSE   8'h0b
`define MSC_ADDR_INTERRUPT_PAD_ONE    8'h0d
`define MSC_ADDR_INTERRUPT_PAD_TWO    8'h0e
`define MSC_ADDR_ID      8'h0f
`define MSC_ADDR_CTRL1   8'h10
`define MSC_ADDR_CTRL2   8'h11
`define MSC_ADDR_CTRL3   8'h12
`define MSC_ADDR_CTRL4   8'h13
`define MSC_ADDR_CTRL5   8'h14
`define MSC_ADDR_CTRL6   8'h15
`define MSC_ADDR_CTRL7   8'h16
`define MSC_MASK_PULSE   8'h81
`define MSC_MASK_CTRL2   8'hfe
`define MSC_MASK_CTRL4   8'hfe
`define MSC_MASK_CTRL6   8'h10
`define MSC_MASK_CTRL7   8'h80
`define MSC_RST_CTRL3    8'h04
`define MSC_ID_VALUE     8'h5c
`define MSC_BIT_PULSED   7
`define MSC_BIT_REBOOT   7
`define MSC_BIT_BDU      6
`define MSC_BIT_POL      5
`define MSC_BIT_DRIVE    4
`define MSC_BIT_SIM      3
`define MSC_BIT_INC      2
`define MSC_BIT_BLE      1
`define MSC_BIT_SWRST    0
`define MSC_BIT_MERGE    5
`define MSC_BIT_I2CDIS   2
`define MSC_BIT_BW0      0
`define MSC_BIT_FS125    1
`define MSC_BIT_HMDIS    4
`define MSC_BIT_GHMDIS   7
`define MSC_PULSE_NS     75000
`define MSC_CLK_NS       8
`define MSC_PULSE_CYC    ((`MSC_PULSE_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_REBOOT_CYC   16
`define MSC_MODE_OFF     2'h0
`define MSC_MODE_LOW     2'h1
`define MSC_MODE_NORM    2'h2
`define MSC_MODE_HIGH    2'h3
`endif

/* File: msc_control_regs.v */
/*
 * Control and configuration register bank of a six-axis motion sensor:
 * ready signalling, interrupt pad routing, identification, rate/range
 * decode, interface options, reboot and self-clearing soft reset.
 * Assumes a serial front end that hands over one byte access per
 * strobe; all inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`include "msc_defs.vh"

module msc_control_regs #(
    parameter PULSE_CYC  = `MSC_PULSE_CYC,
    parameter REBOOT_CYC = `MSC_REBOOT_CYC
) (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire       busStart,
    input  wire [7:0] busAddr,
    input  wire       busWrite,
    input  wire       busRead,
    input  wire [7:0] busWdata,
    output reg  [7:0] busRdata,
    output reg  [7:0] busAddrNow,
    input  wire       accelNew,
    input  wire       gyroNew,
    input  wire       tempNew,
    input  wire       accelRead,
    input  wire       gyroRead,
    input  wire       tempRead,
    input  wire       stepDetect,
    input  wire       sigMotion,
    input  wire       fifoFull,
    input  wire       fifoOverrun,
    input  wire       fifoThreshold,
    input  wire       stepDelta,
    input  wire       stepOverflow,
    input  wire       wristTilt,
    input  wire       pairLowRead,
    input  wire       pairHighRead,
    output reg        pairUpdateAllow,
    output reg        interruptPadOneOut,
    output reg        interruptPadOneOen,
    output reg        interruptPadTwoOut,
    output reg        interruptPadTwoOen,
    output reg        rebootBusy,
    output reg        spiThreeWire,
    output reg        i2cEnable,
    output reg        byteOrderMsbFirst,
    output reg  [3:0] accelRateSel,
    output reg  [1:0] accelPowerMode,
    output reg  [4:0] accelRangeG,
    output reg        accelBandwidthNarrow,
    output reg        accelRateError,
    output reg  [3:0] gyroRateSel,
    output reg  [1:0] gyroPowerMode,
    output reg  [11:0] gyroRangeDps,
    output reg        gyroRateError
);

    // Register storage
    reg  [7:0]  pulseCfg_r;
    reg  [7:0]  int1Ctrl_r;
    reg  [7:0]  int2Ctrl_r;
    reg  [7:0]  ctrl1_r;
    reg  [7:0]  ctrl2_r;
    reg  [7:0]  ctrl3_r;
    reg  [7:0]  ctrl4_r;
    reg  [7:0]  ctrl5_r;
    reg  [7:0]  ctrl6_r;
    reg  [7:0]  ctrl7_r;
    reg  [7:0]  addr_r;
    reg  [15:0] pulseCnt_r;
    reg  [15:0] rebootCnt_r;
    reg  [2:0]  readyLatch_r;
    reg  [2:0]  readyPulse_r;
    reg         pairLowSeen_r;
    reg         pairHighSeen_r;
    reg         softRst_r;
    reg  [7:0]  rdMux;
    wire [7:0]  curAddr;
    wire [2:0]  readyLevel;
    wire        srcOne;
    wire        srcTwo;
    wire        padOne;
    wire        padTwo;

    // Start of burst takes the host address, later bytes use the counter
    assign curAddr = busStart ? busAddr : addr_r;

    // Readback mux; reserved bits are masked at write so read as zero
    always @*
    begin
        case (curAddr)
            `MSC_ADDR_PULSE: rdMux = pulseCfg_r;
            `MSC_ADDR_INTERRUPT_PAD_ONE:  rdMux = int1Ctrl_r;
            `MSC_ADDR_INTERRUPT_PAD_TWO:  rdMux = int2Ctrl_r;
            `MSC_ADDR_ID:    rdMux = `MSC_ID_VALUE;
            `MSC_ADDR_CTRL1: rdMux = ctrl1_r;
            `MSC_ADDR_CTRL2: rdMux = ctrl2_r;
            `MSC_ADDR_CTRL3: rdMux = ctrl3_r;
            `MSC_ADDR_CTRL4: rdMux = ctrl4_r;
            `MSC_ADDR_CTRL5: rdMux = ctrl5_r;
            `MSC_ADDR_CTRL6: rdMux = ctrl6_r;
            `MSC_ADDR_CTRL7: rdMux = ctrl7_r;
            default:         rdMux = 8'h00;
        endcase
    end

    // Register writes, address counter and self-clearing soft reset.
    // Soft reset is applied one cycle after the write so the bit is seen
    // set for exactly one cycle, then this block's registers return to defaults.
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pulseCfg_r <= 8'h00;
            int1Ctrl_r <= 8'h00;
            int2Ctrl_r <= 8'h00;
            ctrl1_r    <= 8'h00;
            ctrl2_r    <= 8'h00;
            ctrl3_r    <= `MSC_RST_CTRL3;
            ctrl4_r    <= 8'h00;
            ctrl5_r    <= 8'h00;
            ctrl6_r    <= 8'h00;
            ctrl7_r    <= 8'h00;
            addr_r     <= 8'h00;
            softRst_r  <= 1'b0;
            busRdata   <= 8'h00;
        end
        else if (softRst_r)
        begin
            pulseCfg_r <= 8'h00;
            int1Ctrl_r <= 8'h00;
            int2Ctrl_r <= 8'h00;
            ctrl1_r    <= 8'h00;
            ctrl2_r    <= 8'h00;
            ctrl3_r    <= `MSC_RST_CTRL3;
            ctrl4_r    <= 8'h00;
            ctrl5_r    <= 8'h00;
            ctrl6_r    <= 8'h00;
            ctrl7_r    <= 8'h00;
            addr_r     <= 8'h00;
            softRst_r  <= 1'b0;
            busRdata   <= 8'h00;
        end
        else
        begin
            if (busRead)
                busRdata <= rdMux;
            // Finished reload drops the request bit, else it restarts
            if (rebootCnt_r == 16'h0001)
                ctrl3_r[`MSC_BIT_REBOOT] <= 1'b0;
            if (busWrite)
            begin
                // Reserved positions are forced to zero on store
                case (curAddr)
                    `MSC_ADDR_PULSE: pulseCfg_r <= busWdata & `MSC_MASK_PULSE;
                    `MSC_ADDR_INTERRUPT_PAD_ONE:  int1Ctrl_r <= busWdata;
                    `MSC_ADDR_INTERRUPT_PAD_TWO:  int2Ctrl_r <= busWdata;
                    `MSC_ADDR_CTRL1: ctrl1_r    <= busWdata;
                    `MSC_ADDR_CTRL2: ctrl2_r    <= busWdata & `MSC_MASK_CTRL2;
                    `MSC_ADDR_CTRL3: ctrl3_r    <= busWdata;
                    `MSC_ADDR_CTRL4: ctrl4_r    <= busWdata & `MSC_MASK_CTRL4;
                    `MSC_ADDR_CTRL5: ctrl5_r    <= busWdata;
                    `MSC_ADDR_CTRL6: ctrl6_r    <= busWdata & `MSC_MASK_CTRL6;
                    `MSC_ADDR_CTRL7: ctrl7_r    <= busWdata & `MSC_MASK_CTRL7;
                    default:         ctrl1_r    <= ctrl1_r; // ID is read-only
                endcase
                if (curAddr == `MSC_ADDR_CTRL3)
                    softRst_r <= busWdata[`MSC_BIT_SWRST];
            end
            // Address advance per byte only when increment is enabled
            if (busRead || busWrite)
                addr_r <= ctrl3_r[`MSC_BIT_INC] ? curAddr + 8'h01 : curAddr;
            else if (busStart)
                addr_r <= busAddr;
        end
    end

    // Ready indications: latched until read, or fixed-length pulse
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            readyLatch_r <= 3'h0;
            readyPulse_r <= 3'h0;
            pulseCnt_r   <= 16'h0000;
        end
        else
        begin
            // Set wins over the clear of the read in the same cycle
            readyLatch_r <= (readyLatch_r & ~{tempRead, gyroRead, accelRead})
                            | {tempNew, gyroNew, accelNew};
            if (accelNew || gyroNew || tempNew)
            begin
                readyPulse_r <= {tempNew, gyroNew, accelNew};
                pulseCnt_r   <= PULSE_CYC[15:0];
            end
            else if (pulseCnt_r > 16'h0001)
                pulseCnt_r <= pulseCnt_r - 16'h0001;
            else
            begin
                pulseCnt_r   <= 16'h0000;
                readyPulse_r <= 3'h0;
            end
        end
    end

    assign readyLevel = pulseCfg_r[`MSC_BIT_PULSED] ? readyPulse_r : readyLatch_r;

    // Source gathering for both pads
    assign srcOne = (int1Ctrl_r[7] & stepDetect) | (int1Ctrl_r[6] & sigMotion)
                  | (int1Ctrl_r[5] & fifoFull) | (int1Ctrl_r[4] & fifoOverrun)
                  | (int1Ctrl_r[3] & fifoThreshold) | (int1Ctrl_r[2] & rebootBusy)
                  | (int1Ctrl_r[1] & readyLevel[1]) | (int1Ctrl_r[0] & readyLevel[0]);
    assign srcTwo = (int2Ctrl_r[7] & stepDelta) | (int2Ctrl_r[6] & stepOverflow)
                  | (int2Ctrl_r[5] & fifoFull) | (int2Ctrl_r[4] & fifoOverrun)
                  | (int2Ctrl_r[3] & fifoThreshold) | (int2Ctrl_r[2] & readyLevel[2])
                  | (int2Ctrl_r[1] & readyLevel[1]) | (int2Ctrl_r[0] & readyLevel[0])
                  | (pulseCfg_r[0] & wristTilt);
    assign padOne = srcOne | (ctrl4_r[`MSC_BIT_MERGE] & srcTwo);
    assign padTwo = srcTwo & ~ctrl4_r[`MSC_BIT_MERGE];

    // Pad drivers; open-drain only pulls the active-low level, else released
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            interruptPadOneOut <= 1'b0;
            interruptPadOneOen <= 1'b0;
            interruptPadTwoOut <= 1'b0;
            interruptPadTwoOen <= 1'b0;
        end
        else
        begin
            interruptPadOneOut <= padOne ^ ctrl3_r[`MSC_BIT_POL];
            interruptPadTwoOut <= padTwo ^ ctrl3_r[`MSC_BIT_POL];
            interruptPadOneOen <= ctrl3_r[`MSC_BIT_DRIVE] & (padOne ^ ctrl3_r[`MSC_BIT_POL]);
            interruptPadTwoOen <= ctrl3_r[`MSC_BIT_DRIVE] & (padTwo ^ ctrl3_r[`MSC_BIT_POL]);
        end
    end

    // Reboot sequence: busy for a fixed reload time, bit clears when done
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rebootCnt_r <= 16'h0000;
            rebootBusy  <= 1'b0;
        end
        else if (rebootCnt_r != 16'h0000)
        begin
            rebootCnt_r <= rebootCnt_r - 16'h0001;
            rebootBusy  <= rebootCnt_r != 16'h0001;
        end
        else if (ctrl3_r[`MSC_BIT_REBOOT] && !rebootBusy)
        begin
            rebootCnt_r <= REBOOT_CYC[15:0];
            rebootBusy  <= 1'b1;
        end
        else
            rebootBusy  <= 1'b0;
    end

    // Block update: a pair refreshes only once both halves were read
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pairLowSeen_r   <= 1'b0;
            pairHighSeen_r  <= 1'b0;
            pairUpdateAllow <= 1'b1;
        end
        else if (!ctrl3_r[`MSC_BIT_BDU])
        begin
            pairLowSeen_r   <= 1'b0;
            pairHighSeen_r  <= 1'b0;
            pairUpdateAllow <= 1'b1;
        end
        else if ((pairLowSeen_r | pairLowRead) && (pairHighSeen_r | pairHighRead))
        begin
            pairLowSeen_r   <= 1'b0;
            pairHighSeen_r  <= 1'b0;
            pairUpdateAllow <= 1'b1;
        end
        else
        begin
            pairLowSeen_r   <= pairLowSeen_r | pairLowRead;
            pairHighSeen_r  <= pairHighSeen_r | pairHighRead;
            pairUpdateAllow <= 1'b0;
        end
    end

    // Mode decode of rate, range and power; outputs registered
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            busAddrNow           <= 8'h00;
            spiThreeWire         <= 1'b0;
            i2cEnable            <= 1'b1;
            byteOrderMsbFirst    <= 1'b0;
            accelRateSel         <= 4'h0;
            accelPowerMode       <= `MSC_MODE_OFF;
            accelRangeG          <= 5'd2;
            accelBandwidthNarrow <= 1'b0;
            accelRateError       <= 1'b0;
            gyroRateSel          <= 4'h0;
            gyroPowerMode        <= `MSC_MODE_OFF;
            gyroRangeDps         <= 12'd250;
            gyroRateError        <= 1'b0;
        end
        else
        begin
            busAddrNow        <= addr_r;
            spiThreeWire      <= ctrl3_r[`MSC_BIT_SIM];
            i2cEnable         <= ~ctrl4_r[`MSC_BIT_I2CDIS];
            byteOrderMsbFirst <= ctrl3_r[`MSC_BIT_BLE];
            // Code 1011 means 1.6 Hz only with high performance off
            accelRateSel   <= ctrl1_r[7:4];
            accelRateError <= ctrl1_r[7:6] == 2'b11;
            if (ctrl1_r[7:4] == 4'h0 || ctrl1_r[7:6] == 2'b11)
                accelPowerMode <= `MSC_MODE_OFF;
            else if (!ctrl6_r[`MSC_BIT_HMDIS] || (ctrl1_r[7:4] >= 4'h6 && ctrl1_r[7:4] <= 4'ha))
                accelPowerMode <= `MSC_MODE_HIGH;
            else if (ctrl1_r[7:4] == 4'h4 || ctrl1_r[7:4] == 4'h5)
                accelPowerMode <= `MSC_MODE_NORM;
            else
                accelPowerMode <= `MSC_MODE_LOW;
            case (ctrl1_r[3:2])
                2'b00:   accelRangeG <= 5'd2;
                2'b01:   accelRangeG <= 5'd16;
                2'b10:   accelRangeG <= 5'd4;
                default: accelRangeG <= 5'd8;
            endcase
            // Analog bandwidth bit only acts at 1.66 kHz and above
            accelBandwidthNarrow <= ctrl1_r[`MSC_BIT_BW0] &&
                                    ctrl1_r[7:4] >= 4'h8 && ctrl1_r[7:4] <= 4'ha;
            gyroRateSel   <= ctrl2_r[7:4];
            gyroRateError <= ctrl2_r[7:4] >= 4'hb;
            if (ctrl2_r[7:4] == 4'h0 || ctrl2_r[7:4] >= 4'hb)
                gyroPowerMode <= `MSC_MODE_OFF;
            else if (!ctrl7_r[`MSC_BIT_GHMDIS] || ctrl2_r[7:4] >= 4'h6)
                gyroPowerMode <= `MSC_MODE_HIGH;
            else if (ctrl2_r[7:4] >= 4'h4)
                gyroPowerMode <= `MSC_MODE_NORM;
            else
                gyroPowerMode <= `MSC_MODE_LOW;
            if (ctrl2_r[`MSC_BIT_FS125])
                gyroRangeDps <= 12'd125;
            else
                gyroRangeDps <= 12'd250 << ctrl2_r[3:2];
        end
    end

endmodule // msc_control_regs

/* File: msc_host_model.sv */
/* Host model for the register port: one byte access per cycle.
   Assumes clk_sys from the bench; requests held edge to edge. */
`timescale 1ns/1ps
`include "msc_defs.vh"
module msc_host_model (
    input  wire       clk_sys,
    output reg        busStart,
    output reg  [7:0] busAddr,
    output reg        busWrite,
    output reg        busRead,
    output reg  [7:0] busWdata
);
    // Quiet bus at time zero
    initial {busStart, busWrite, busRead, busAddr, busWdata} = 19'h0;

    // Reserved positions always leave the host as zero
    function [7:0] keepMask(input [7:0] a);
        case (a)
            `MSC_ADDR_PULSE: keepMask = `MSC_MASK_PULSE;
            `MSC_ADDR_CTRL2: keepMask = `MSC_MASK_CTRL2;
            `MSC_ADDR_CTRL4: keepMask = `MSC_MASK_CTRL4;
            `MSC_ADDR_CTRL6: keepMask = `MSC_MASK_CTRL6;
            `MSC_ADDR_CTRL7: keepMask = `MSC_MASK_CTRL7;
            default: keepMask = 8'hff;
        endcase
    endfunction

    // Unused fields scrambled so a stale value never looks valid
    task xfer(input st, input [7:0] a, input wr, input [7:0] d);
        begin
            @(posedge clk_sys);
            #1;
            busStart = st;
            busAddr  = st ? a : ~busAddr;
            busWrite = wr;
            busRead  = !wr;
            busWdata = wr ? (d & keepMask(a)) : ~busWdata;
        end
    endtask

    // Release after the edge that took the last request
    task idle;
        begin
            @(posedge clk_sys);
            #1;
            {busStart, busWrite, busRead} = 3'h0;
            busAddr  = ~busAddr;
        end
    endtask
endmodule // msc_host_model

/* File: msc_control_regs_checker.sv */
/* Port-level assertions for the control register bank.
   Assumes one clock domain and the bank's active-low reset. */
`timescale 1ns/1ps
`include "msc_defs.vh"
module msc_control_regs_checker (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       busStart,
    input wire logic [7:0] busAddr,
    input wire logic       busWrite,
    input wire logic       busRead,
    input wire logic [7:0] busRdata,
    input wire logic [7:0] busAddrNow,
    input wire logic       rebootBusy,
    input wire logic       interruptPadOneOut,
    input wire logic       interruptPadOneOen,
    input wire logic       interruptPadTwoOut,
    input wire logic       interruptPadTwoOen,
    input wire logic [3:0] accelRateSel,
    input wire logic [1:0] accelPowerMode,
    input wire logic       accelRateError,
    input wire logic       accelBandwidthNarrow,
    input wire logic [4:0] accelRangeG
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_id_fixed: assert property (busRead && busStart && busAddr == `MSC_ADDR_ID |=> busRdata == `MSC_ID_VALUE)
        else $error("identification byte wrong");
    a_addr_step: assert property ((busWrite || busRead) && busStart |-> ##2
        busAddrNow - $past(busAddr, 2) <= 8'h1)
        else $error("address counter step wrong");
    a_reboot_len: assert property ($rose(rebootBusy) |-> rebootBusy [*8] ##[1:12] !rebootBusy)
        else $error("reload length wrong");
    a_pad_one_od: assert property (interruptPadOneOen |-> interruptPadOneOut)
        else $error("pad one released while low");
    a_pad_two_od: assert property (interruptPadTwoOen |-> interruptPadTwoOut)
        else $error("pad two released while low");
    a_rate_high: assert property (accelRateSel inside {[4'h6:4'ha]} |-> accelPowerMode == `MSC_MODE_HIGH)
        else $error("fast rate not in high performance");
    a_rate_refused: assert property (accelRateSel[3:2] == 2'b11 |-> accelRateError)
        else $error("forbidden rate not flagged");
    a_bw_fast_only: assert property (accelBandwidthNarrow |-> accelRateSel inside {[4'h8:4'ha]})
        else $error("narrow bandwidth at slow rate");
    a_range_legal: assert property (accelRangeG inside {5'd2, 5'd4, 5'd8, 5'd16})
        else $error("accel range value illegal");

    c_reboot: cover property ($rose(rebootBusy));
    c_refused: cover property (accelRateError);
    c_released: cover property (interruptPadOneOen);
endmodule // msc_control_regs_checker

bind msc_control_regs msc_control_regs_checker u_checker (
    .clk_sys, .nrst, .busStart, .busAddr, .busWrite, .busRead, .busRdata, .busAddrNow, .rebootBusy,
    .interruptPadOneOut, .interruptPadOneOen, .interruptPadTwoOut, .interruptPadTwoOen,
    .accelRateSel, .accelPowerMode, .accelRateError, .accelBandwidthNarrow, .accelRangeG
);

/* File: test_msc_control_regs.sv */
/* Self-checking bench for the control register bank: host model on the
   register port, random sources, queued read expectations.
   Assumes the bank, host model and checker are compiled first. */
`timescale 1ns/1ps
`include "msc_defs.vh"
module test_msc_control_regs;
    localparam PCYC = 8;
    reg          clk_sys = 1'b0;
    reg          nrst = 1'b0;
    reg  [2:0]   newV = 3'h0;   // accel, gyro, temp
    reg  [2:0]   rdV = 3'h0;
    reg  [7:0]   srcV = 8'h0;   // step,sig,full,ovr,fth,delta,ovf,tilt
    reg  [1:0]   pairRd = 2'h0;
    reg          rdPend = 1'b0;
    integer      seed = 32'hdb25e698;
    integer      failures = 0;
    integer      tests_run = 0;
    integer      i, k, n, gk;
    logic [7:0]  expQ[$];
    logic [7:0]  d, e1, e2;
    logic        p1, p2, pol, od, mg, tw;
    logic [7:0]  addrV [0:6] = '{8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13, 8'h14};
    logic [7:0]  keepV [0:6] = '{8'h81, 8'hff, 8'hff, 8'h3f, 8'h3e, 8'hfe, 8'hf0};
    logic [4:0]  gMap [0:3] = '{5'd2, 5'd16, 5'd4, 5'd8};
    logic [11:0] dMap [0:3] = '{12'd250, 12'd500, 12'd1000, 12'd2000};
    wire  [7:0]  busAddr, busWdata, busRdata, busAddrNow;
    wire         busStart, busWrite, busRead, pairOk, pad1, oen1, pad2, oen2, boot;
    wire         spi3, i2cOn, msbFirst, aBw, aErr, gErr;
    wire  [3:0]  aRate, gRate;
    wire  [1:0]  aMode, gMode;
    wire  [4:0]  aRange;
    wire  [11:0] gRange;

    always #4 clk_sys = ~clk_sys;

    msc_host_model host (.clk_sys(clk_sys), .busStart(busStart), .busAddr(busAddr),
        .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata));

    msc_control_regs #(.PULSE_CYC(PCYC)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .busStart(busStart), .busAddr(busAddr),
        .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
        .busAddrNow(busAddrNow), .accelNew(newV[0]), .gyroNew(newV[1]), .tempNew(newV[2]),
        .accelRead(rdV[0]), .gyroRead(rdV[1]), .tempRead(rdV[2]), .stepDetect(srcV[7]),
        .sigMotion(srcV[6]), .fifoFull(srcV[5]), .fifoOverrun(srcV[4]), .fifoThreshold(srcV[3]),
        .stepDelta(srcV[2]), .stepOverflow(srcV[1]), .wristTilt(srcV[0]),
        .pairLowRead(pairRd[0]), .pairHighRead(pairRd[1]), .pairUpdateAllow(pairOk),
        .interruptPadOneOut(pad1), .interruptPadOneOen(oen1), .interruptPadTwoOut(pad2),
        .interruptPadTwoOen(oen2), .rebootBusy(boot), .spiThreeWire(spi3), .i2cEnable(i2cOn),
        .byteOrderMsbFirst(msbFirst), .accelRateSel(aRate), .accelPowerMode(aMode),
        .accelRangeG(aRange), .accelBandwidthNarrow(aBw), .accelRateError(aErr),
        .gyroRateSel(gRate), .gyroPowerMode(gMode), .gyroRangeDps(gRange), .gyroRateError(gErr));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task tick(input integer c);
        begin
            repeat (c) @(posedge clk_sys);
            #1;
        end
    endtask

    task wr(input [7:0] a, input [7:0] v);
        begin
            host.xfer(1'b1, a, 1'b1, v);
            host.idle;
        end
    endtask

    // Expectation noted before the request leaves
    task rd(input [7:0] a, input [7:0] v);
        begin
            expQ.push_back(v);
            host.xfer(1'b1, a, 1'b0, 8'h0);
            host.idle;
        end
    endtask

    // Power mode a rate code should give; c = 11 is the slow low-power code
    function [1:0] modeOf(input integer c, input integer hd);
        if (c == 0)
            modeOf = `MSC_MODE_OFF;
        else if (hd == 0 || (c > 5 && c < 11))
            modeOf = `MSC_MODE_HIGH;
        else if (c > 3 && c < 11)
            modeOf = `MSC_MODE_NORM;
        else
            modeOf = `MSC_MODE_LOW;
    endfunction

    // Read data lands one cycle after the request edge; oldest note first
    always @(posedge clk_sys)
    begin
        if (rdPend)
            check(busRdata, expQ.pop_front());
        rdPend = busRead;
    end

    // Hang guard
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        failures = failures + 1;
        complete_run;
    end

    initial
    begin
        tick(3);
        nrst = 1'b1;
        // Reset image as one auto-incrementing burst, 0x0c unmapped
        expQ = '{8'h0, 8'h0, 8'h0, 8'h0, `MSC_ID_VALUE, 8'h0, 8'h0, `MSC_RST_CTRL3, 8'h0, 8'h0};
        for (i = 0; i < 10; i = i + 1)
            host.xfer(i == 0, 8'h0b, 1'b0, 8'h0);
        host.idle;
        check({i2cOn, pairOk, spi3, msbFirst, aRange, gRange}, {4'hc, 5'd2, 12'd250});
        // Random write and read-back; forbidden codes kept out
        for (i = 0; i < 14; i = i + 1)
        begin
            d = $random(seed) & keepV[i % 7];
            wr(addrV[i % 7], d);
            rd(addrV[i % 7], d);
        end
        wr(8'h0f, 8'ha5);
        rd(8'h0f, `MSC_ID_VALUE);
        wr(8'h20, 8'h5a);
        rd(8'h20, 8'h00);
        // Increment off: second byte lands at the same place
        wr(8'h12, 8'h00);
        host.xfer(1'b1, 8'h10, 1'b1, 8'h21);
        host.xfer(1'b0, 8'h10, 1'b1, 8'h32);
        host.idle;
        check(busAddrNow, 8'h10);
        rd(8'h10, 8'h32);
        wr(8'h12, 8'h04);
        // Accel rate codes 0 to 12 and gyro codes 0 to 11 in both performance settings, ranges alongside
        for (i = 0; i < 26; i = i + 1)
        begin
            k = i % 13;
            n = i / 13;
            gk = (k > 11) ? 11 : k;
            wr(8'h15, {3'h0, n[0], 4'h0});
            wr(8'h16, {n[0], 7'h0});
            wr(8'h10, {k[3:0], k[1:0], 2'h1});
            wr(8'h11, {gk[3:0], k[1:0], k[2], 1'b0});
            tick(2);
            if (k < 12)
                check({aRate, aMode}, {k[3:0], modeOf(k, n)});
            if (k < 11)
                check({gRate, gMode}, {k[3:0], modeOf(k, n)});
            check({aErr, gErr}, {k > 11, gk == 11});
            check(aRange, gMap[k[1:0]]);
            check(gRange, k[2] ? 12'd125 : dMap[k[1:0]]);
            if (k != 8 && k < 12)
                check(aBw, k == 9 || k == 10);
        end
        // Random enables, sources, polarity, drive and merge
        for (i = 0; i < 24; i = i + 1)
        begin
            {e1, e2, d} = $random(seed);
            {pol, od, mg, tw} = $random(seed);
            wr(8'h0d, {e1[7:3], 3'h0});
            wr(8'h0e, {e2[7:3], 3'h0});
            wr(8'h0b, {7'h0, tw});
            wr(8'h12, {2'h0, pol, od, 4'h4});
            wr(8'h13, {2'h0, mg, 5'h0});
            srcV = d;
            tick(3);
            p1 = |(e1[7:3] & srcV[7:3]);
            p2 = |(e2[7:3] & {srcV[2:1], srcV[5:3]}) | (tw & srcV[0]);
            p1 = p1 | (mg & p2);
            check({pad1, oen1}, {p1 ^ pol, od & (p1 ^ pol)});
            if (!mg)
                check({pad2, oen2}, {p2 ^ pol, od & (p2 ^ pol)});
        end
        srcV = 8'h0;
        wr(8'h13, 8'h00);
        wr(8'h12, 8'h04);
        wr(8'h0e, 8'h07);
        wr(8'h0d, 8'h03);
        // Latched ready per sensor: set by a sample, cleared by its read
        for (k = 0; k < 3; k = k + 1)
        begin
            newV[k] = 1'b1;
            tick(1);
            newV = 3'h0;
            tick(5);
            check(pad2, 1'b1);
            check(pad1, k < 2);
            rdV[k] = 1'b1;
            tick(1);
            rdV = 3'h0;
            tick(2);
            check(pad2, 1'b0);
        end
        // Pulsed ready: cycles the pad stands high, no read given
        wr(8'h0b, 8'h80);
        newV = 3'h1;
        tick(1);
        newV = 3'h0;
        n = 0;
        for (i = 0; i < 40; i = i + 1)
        begin
            tick(1);
            n = n + pad2;
        end
        check(n, PCYC);
        rdV = 3'h1;
        tick(1);
        rdV = 3'h0;
        wr(8'h0b, 8'h00);
        // Held pair: refresh allowed once, after both halves were read
        wr(8'h12, 8'h44);
        tick(1);
        check(pairOk, 1'b0);
        pairRd = 2'h1;
        tick(1);
        pairRd = 2'h0;
        tick(1);
        check(pairOk, 1'b0);
        pairRd = 2'h2;
        tick(1);
        pairRd = 2'h0;
        n = 0;
        for (i = 0; i < 4; i = i + 1)
        begin
            n = n + (pairOk === 1'b1);
            tick(1);
        end
        check(n, 1);
        wr(8'h12, 8'h0e);
        wr(8'h13, 8'h04);
        tick(1);
        check({i2cOn, spi3, msbFirst}, 3'h3);
        // Reload runs a fixed number of cycles
        wr(8'h12, 8'h84);
        n = 0;
        for (i = 0; i < 40; i = i + 1)
        begin
            n = n + boot;
            tick(1);
        end
        check(n, `MSC_REBOOT_CYC);
        wr(8'h10, 8'h60);
        wr(8'h12, 8'h05);
        tick(2);
        rd(8'h12, `MSC_RST_CTRL3);
        rd(8'h10, 8'h00);
        check({i2cOn, spi3, msbFirst}, 3'h4);
        tick(3);
        complete_run;
    end
endmodule // test_msc_control_regs
